// *** oso_pkg.sv ***
`default_nettype none
package oso_pkg;
  localparam int VAL_DEPTH = 1002;
  localparam int SEQ_DEPTH = 512;
  localparam int AW = 10;
  localparam int SW = 9;
  localparam int DW = 16;
  localparam int RD_BURST = 16;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = (TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [AW-1:0] VAL_DEPTH_W = 10'h3EA;
  localparam logic [AW-1:0] SEQ_DEPTH_W = 10'h200;
  localparam logic [AW-1:0] PTS_MAX = 10'h3E9;
  localparam logic [15:0] SEQ_ARG_MAX = 16'h01FF;
  localparam logic [15:0] QPTR_MAX = 16'h03E9;
  localparam logic [4:0] BURST_LEN = 5'h10;
  localparam logic [15:0] ERR_CONFLICT = 16'hFF23;
  localparam logic [15:0] ERR_RANGE = 16'hFF22;
  localparam logic signed [15:0] QUARTER_FS = 16'sh1FFF;
  localparam logic signed [15:0] NEG_QUARTER_FS = 16'shE001;
  localparam logic [15:0] SCALE_QUARTER_CODE = 16'h0004;
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [15:0] SKIP_RST = 16'h0000;
  localparam logic [15:0] SETPOINT_RST = 16'h0000;
  localparam logic [15:0] TOKEN_NATURAL = 16'h0000;
  localparam logic [15:0] TOKEN_USER = 16'h0001;
  localparam logic [15:0] TOKEN_UP = 16'h0000;
  localparam logic [15:0] TOKEN_DOWN = 16'h0001;

  typedef enum logic [4:0] {
    OP_NOP, OP_CLEAR, OP_VALUE_WR, OP_DWELL_WR, OP_SEQ_WR,
    OP_ORDER_NATURAL, OP_ORDER_USER, OP_ORDER_Q, OP_DIR_UP, OP_DIR_DOWN, OP_DIR_Q,
    OP_COUNT_SET, OP_COUNT_Q, OP_SKIP_SET, OP_SKIP_Q, OP_QPTR_SET, OP_QPTR_Q,
    OP_VALUE_PTS_Q, OP_DWELL_PTS_Q, OP_VALUE_RD, OP_DWELL_RD, OP_SEQ_RD,
    OP_RUN, OP_FIX, OP_TRAN, OP_SETPOINT_WR, OP_SETPOINT_Q, OP_SCALE_SET
  } oso_op_t;
endpackage
`default_nettype wire

// *** oso_store.sv ***
`timescale 1ns/1ns
`default_nettype none
module oso_store #(
  parameter int W = 16,
  parameter int DEPTH = 1002,
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  // entries hold list data only, so they need no reset
  always_ff @(posedge clk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_comb begin
    rd_data = '0;
    if (int'(rd_addr) < DEPTH) begin
      rd_data = mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// *** oso_tick.sv ***
`timescale 1ns/1ns
`default_nettype none
module oso_tick #(
  parameter int DIV = 2000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  output logic tick
);
  logic [15:0] cnt_q;

  // one-cycle enable every DIV clocks, restarted by clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
    end else if (clear || (cnt_q == 16'(DIV - 1))) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign tick = !clear && (cnt_q == 16'(DIV - 1));
endmodule
`default_nettype wire

// *** oso_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module oso_sequencer #(
  parameter int TICK_DIV = oso_pkg::TICK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire oso_pkg::oso_op_t CMD_OP,
  input wire logic [15:0] CMD_ARG,
  output logic RSP_VALID,
  output logic [15:0] RSP_DATA,
  output logic RSP_LAST,
  output logic ERR_VALID,
  output logic [15:0] ERR_CODE,
  output logic [15:0] SETPOINT,
  output logic RUNNING,
  output logic ORDER_USER,
  output logic DIR_DOWN
);
  import oso_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_STEP, S_DWELL, S_BURST} oso_state_t;

  oso_state_t state_q;
  logic [AW-1:0] val_cnt_q, dwell_cnt_q, seq_cnt_q, qptr_q, pos_q, rb_addr_q;
  logic [15:0] count_q, skip_q, pass_q, dw_q;
  logic [15:0] setpoint_q, prev_q, tran_dur_q, tran_cnt_q;
  logic order_user_q, dir_down_q, scale_qtr_q, tran_armed_q, tran_active_q;
  logic [4:0] rb_left_q;
  logic [1:0] rb_tab_q;
  logic rsp_valid_q, rsp_last_q, err_valid_q;
  logic [15:0] rsp_data_q, err_code_q;
  logic cmd_take, locked_op, running, reject, act, tick, tick_clr;
  logic rd_op, query_op, bal_ok, last_step, more_pass, restart_ok, bad_arg;
  logic tran_load, set_load, val_we, dwell_we, seq_we;
  logic [AW-1:0] len, eff_pos, loc, val_ra, tab_cnt, avail;
  logic [SW-1:0] seq_ra, seq_rd;
  logic [15:0] val_rd, dwell_rd, query_data;
  logic [4:0] burst_n;

  oso_store #(.W(DW), .DEPTH(VAL_DEPTH), .AW(AW)) u_values (
    .clk(CLOCK), .wr_en(val_we), .wr_addr(val_cnt_q), .wr_data(CMD_ARG),
    .rd_addr(val_ra), .rd_data(val_rd));
  oso_store #(.W(DW), .DEPTH(VAL_DEPTH), .AW(AW)) u_dwells (
    .clk(CLOCK), .wr_en(dwell_we), .wr_addr(dwell_cnt_q), .wr_data(CMD_ARG),
    .rd_addr(val_ra), .rd_data(dwell_rd));
  oso_store #(.W(SW), .DEPTH(SEQ_DEPTH), .AW(SW)) u_index (
    .clk(CLOCK), .wr_en(seq_we), .wr_addr(seq_cnt_q[SW-1:0]), .wr_data(CMD_ARG[SW-1:0]),
    .rd_addr(seq_ra), .rd_data(seq_rd));
  oso_tick #(.DIV(TICK_DIV)) u_tick (
    .clk(CLOCK), .arst_n(ARST_N), .clear(tick_clr), .tick(tick));

  // command decode
  always_comb begin
    CMD_READY = (state_q != S_BURST);
    cmd_take = CMD_VALID && CMD_READY;
    running = (state_q == S_STEP) || (state_q == S_DWELL);
    locked_op = !(CMD_OP inside {OP_NOP, OP_FIX, OP_SETPOINT_Q});
    reject = running && locked_op;
    act = cmd_take && !reject;
    rd_op = CMD_OP inside {OP_VALUE_RD, OP_DWELL_RD, OP_SEQ_RD};
    query_op = CMD_OP inside {OP_ORDER_Q, OP_DIR_Q, OP_COUNT_Q, OP_SKIP_Q, OP_QPTR_Q,
                              OP_VALUE_PTS_Q, OP_DWELL_PTS_Q, OP_SETPOINT_Q};
    bal_ok = (val_cnt_q == dwell_cnt_q);
    unique case (CMD_OP)
      OP_VALUE_WR: bad_arg = (val_cnt_q >= VAL_DEPTH_W);
      OP_DWELL_WR: bad_arg = (dwell_cnt_q >= VAL_DEPTH_W);
      OP_SEQ_WR: bad_arg = (seq_cnt_q >= SEQ_DEPTH_W) || (CMD_ARG > SEQ_ARG_MAX);
      OP_QPTR_SET: bad_arg = (CMD_ARG > QPTR_MAX);
      OP_SETPOINT_WR: bad_arg = scale_qtr_q && (($signed(CMD_ARG) > QUARTER_FS) ||
                                                ($signed(CMD_ARG) < NEG_QUARTER_FS));
      default: bad_arg = 1'b0;
    endcase
    val_we = act && (CMD_OP == OP_VALUE_WR) && !bad_arg;
    dwell_we = act && (CMD_OP == OP_DWELL_WR) && !bad_arg;
    seq_we = act && (CMD_OP == OP_SEQ_WR) && !bad_arg;
    set_load = act && (CMD_OP == OP_SETPOINT_WR) && !bad_arg;
    tran_load = set_load && tran_armed_q;
  end

  // traversal addressing
  always_comb begin
    len = order_user_q ? seq_cnt_q : val_cnt_q;
    eff_pos = dir_down_q ? (len - pos_q - 10'h001) : pos_q;
    seq_ra = running ? eff_pos[SW-1:0] : rb_addr_q[SW-1:0];
    loc = order_user_q ? {1'b0, seq_rd} : eff_pos;
    val_ra = running ? loc : rb_addr_q;
    last_step = ((pos_q + 10'h001) >= len);
    more_pass = (count_q == 16'h0000) || (pass_q < count_q);
    restart_ok = (skip_q < {6'h00, len});
    tick_clr = (state_q == S_STEP) || tran_load;
    unique case (CMD_OP)
      OP_DWELL_RD: tab_cnt = dwell_cnt_q;
      OP_SEQ_RD: tab_cnt = seq_cnt_q;
      default: tab_cnt = val_cnt_q;
    endcase
    avail = (qptr_q < tab_cnt) ? (tab_cnt - qptr_q) : 10'h000;
    burst_n = (avail > {5'h00, BURST_LEN}) ? BURST_LEN : avail[4:0];
  end

  // step sequencing
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= S_IDLE;
      pos_q <= 10'h000;
      pass_q <= 16'h0000;
      dw_q <= 16'h0000;
    end else if (act && (CMD_OP == OP_FIX)) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (act && (CMD_OP == OP_RUN) && bal_ok && (len != 10'h000)) begin
            pos_q <= 10'h000;
            pass_q <= 16'h0001;
            state_q <= S_STEP;
          end else if (act && rd_op && (avail != 10'h000)) begin
            state_q <= S_BURST;
          end
        end
        S_STEP: begin
          dw_q <= dwell_rd;
          state_q <= S_DWELL;
        end
        S_DWELL: begin
          if (dw_q == 16'h0000) begin
            if (!last_step) begin
              pos_q <= pos_q + 10'h001;
              state_q <= S_STEP;
            end else if (more_pass && restart_ok) begin
              pass_q <= pass_q + 16'h0001;
              pos_q <= skip_q[AW-1:0];
              state_q <= S_STEP;
            end else begin
              state_q <= S_IDLE;
            end
          end else if (tick) begin
            dw_q <= dw_q - 16'h0001;
          end
        end
        S_BURST: begin
          if (rb_left_q <= 5'h01) begin
            state_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // read-back walker
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rb_addr_q <= 10'h000;
      rb_left_q <= 5'h00;
      rb_tab_q <= 2'h0;
    end else if (state_q == S_BURST) begin
      rb_addr_q <= rb_addr_q + 10'h001;
      rb_left_q <= rb_left_q - 5'h01;
    end else if (act && rd_op) begin
      rb_addr_q <= qptr_q;
      rb_left_q <= burst_n;
      rb_tab_q <= (CMD_OP == OP_VALUE_RD) ? 2'h0 : ((CMD_OP == OP_DWELL_RD) ? 2'h1 : 2'h2);
    end
  end

  // list configuration
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      val_cnt_q <= 10'h000;
      dwell_cnt_q <= 10'h000;
      seq_cnt_q <= 10'h000;
      qptr_q <= 10'h000;
      order_user_q <= 1'b0;
      dir_down_q <= 1'b0;
      count_q <= COUNT_RST;
      skip_q <= SKIP_RST;
      scale_qtr_q <= 1'b0;
    end else if (act) begin
      unique case (CMD_OP)
        OP_CLEAR: begin
          val_cnt_q <= 10'h000;
          dwell_cnt_q <= 10'h000;
          seq_cnt_q <= 10'h000;
          qptr_q <= 10'h000;
        end
        OP_VALUE_WR: if (!bad_arg) val_cnt_q <= val_cnt_q + 10'h001;
        OP_DWELL_WR: if (!bad_arg) dwell_cnt_q <= dwell_cnt_q + 10'h001;
        OP_SEQ_WR: if (!bad_arg) seq_cnt_q <= seq_cnt_q + 10'h001;
        OP_ORDER_NATURAL: order_user_q <= 1'b0;
        OP_ORDER_USER: order_user_q <= 1'b1;
        OP_DIR_UP: dir_down_q <= 1'b0;
        OP_DIR_DOWN: dir_down_q <= 1'b1;
        OP_COUNT_SET: count_q <= CMD_ARG;
        OP_SKIP_SET: skip_q <= CMD_ARG;
        OP_QPTR_SET: if (!bad_arg) qptr_q <= CMD_ARG[AW-1:0];
        OP_SCALE_SET: scale_qtr_q <= (CMD_ARG == SCALE_QUARTER_CODE);
        default: ;
      endcase
    end
  end

  // setpoint and transient
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      setpoint_q <= SETPOINT_RST;
      prev_q <= SETPOINT_RST;
      tran_armed_q <= 1'b0;
      tran_dur_q <= 16'h0000;
      tran_cnt_q <= 16'h0000;
      tran_active_q <= 1'b0;
    end else begin
      if (act && (CMD_OP == OP_TRAN)) begin
        tran_armed_q <= 1'b1;
        tran_dur_q <= CMD_ARG;
      end else if (act && ((CMD_OP == OP_FIX) || (CMD_OP == OP_RUN))) begin
        tran_armed_q <= 1'b0;
      end
      if (state_q == S_STEP) begin
        setpoint_q <= val_rd;
      end else if (tran_load) begin
        prev_q <= setpoint_q;
        setpoint_q <= CMD_ARG;
        tran_cnt_q <= tran_dur_q;
        tran_active_q <= 1'b1;
      end else if (set_load) begin
        setpoint_q <= CMD_ARG;
      end else if (tran_active_q && tick) begin
        if (tran_cnt_q <= 16'h0001) begin
          setpoint_q <= prev_q;
          tran_active_q <= 1'b0;
        end else begin
          tran_cnt_q <= tran_cnt_q - 16'h0001;
        end
      end
    end
  end

  // scalar query answers
  always_comb begin
    unique case (CMD_OP)
      OP_ORDER_Q: query_data = order_user_q ? TOKEN_USER : TOKEN_NATURAL;
      OP_DIR_Q: query_data = dir_down_q ? TOKEN_DOWN : TOKEN_UP;
      OP_COUNT_Q: query_data = count_q;
      OP_SKIP_Q: query_data = skip_q;
      OP_QPTR_Q: query_data = {6'h00, qptr_q};
      OP_VALUE_PTS_Q: query_data = {6'h00, (val_cnt_q > PTS_MAX) ? PTS_MAX : val_cnt_q};
      OP_DWELL_PTS_Q: query_data = {6'h00, (dwell_cnt_q > PTS_MAX) ? PTS_MAX : dwell_cnt_q};
      OP_SETPOINT_Q: query_data = setpoint_q;
      default: query_data = 16'h0000;
    endcase
  end

  // response channel
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rsp_valid_q <= 1'b0;
      rsp_last_q <= 1'b0;
      rsp_data_q <= 16'h0000;
    end else if (state_q == S_BURST) begin
      rsp_valid_q <= 1'b1;
      rsp_last_q <= (rb_left_q == 5'h01);
      unique case (rb_tab_q)
        2'h1: rsp_data_q <= dwell_rd;
        2'h2: rsp_data_q <= {7'h00, seq_rd};
        default: rsp_data_q <= val_rd;
      endcase
    end else if (act && (query_op || (rd_op && (avail == 10'h000)))) begin
      rsp_valid_q <= 1'b1;
      rsp_last_q <= 1'b1;
      rsp_data_q <= query_data;
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_last_q <= 1'b0;
    end
  end

  // error reporting
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      err_valid_q <= 1'b0;
      err_code_q <= 16'h0000;
    end else if (cmd_take && reject) begin
      err_valid_q <= 1'b1;
      err_code_q <= ERR_CONFLICT;
    end else if (act && (CMD_OP == OP_RUN) && !bal_ok) begin
      err_valid_q <= 1'b1;
      err_code_q <= ERR_CONFLICT;
    end else if (act && bad_arg) begin
      err_valid_q <= 1'b1;
      err_code_q <= ERR_RANGE;
    end else begin
      err_valid_q <= 1'b0;
    end
  end

  assign RSP_VALID = rsp_valid_q;
  assign RSP_DATA = rsp_data_q;
  assign RSP_LAST = rsp_last_q;
  assign ERR_VALID = err_valid_q;
  assign ERR_CODE = err_code_q;
  assign SETPOINT = setpoint_q;
  assign RUNNING = running;
  assign ORDER_USER = order_user_q;
  assign DIR_DOWN = dir_down_q;

  // checks
  logic [4:0] burst_n_q;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      burst_n_q <= 5'h00;
    end else begin
      burst_n_q <= RSP_VALID ? (RSP_LAST ? 5'h00 : burst_n_q + 5'h01) : 5'h00;
    end
  end

  a_list_reject: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (cmd_take && running && locked_op) |=> (ERR_VALID && (ERR_CODE == ERR_CONFLICT) && RUNNING))
    else $error("list command during run not refused");
  a_unbalanced_run: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (cmd_take && (state_q == S_IDLE) && (CMD_OP == OP_RUN) && (val_cnt_q != dwell_cnt_q))
    |=> (ERR_VALID && (ERR_CODE == ERR_CONFLICT)) ##0 !RUNNING [*2])
    else $error("unbalanced list started");
  a_fix_stops: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (cmd_take && (CMD_OP == OP_FIX)) |=> !RUNNING)
    else $error("fixed mode did not stop run");
  a_step_value: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (state_q == S_STEP) |=> ((SETPOINT == $past(val_rd)) && (state_q == S_DWELL || !RUNNING)))
    else $error("step value not applied");
  a_hold_after: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    ($fell(RUNNING) && !set_load) |=> $stable(SETPOINT))
    else $error("setpoint moved at end of run");
  a_pts_capped: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (act && (CMD_OP == OP_VALUE_PTS_Q)) |=> (RSP_VALID && RSP_LAST && (RSP_DATA <= 16'h03E9)))
    else $error("point count above limit");
  a_burst_len: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    RSP_VALID |-> (burst_n_q < BURST_LEN))
    else $error("read-back longer than sixteen");
  a_value_append: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    val_we |=> (val_cnt_q == $past(val_cnt_q) + 10'h001))
    else $error("value append pointer wrong");
  a_quarter_scale: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (act && (CMD_OP == OP_SETPOINT_WR) && scale_qtr_q && ($signed(CMD_ARG) > QUARTER_FS))
    |=> (ERR_VALID && (ERR_CODE == ERR_RANGE) && $stable(SETPOINT)))
    else $error("quarter scale limit not enforced");
endmodule
`default_nettype wire

// *** oso_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module oso_host (
  input wire logic clk,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output oso_pkg::oso_op_t cmd_op,
  output logic [15:0] cmd_arg,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_last,
  input wire logic err_valid
);
  import oso_pkg::*;
  logic [15:0] rsp_q[$];
  logic err_seen;
  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_NOP;
    cmd_arg = 16'h0000;
    err_seen = 1'b0;
  end
  // one command: held until taken, then answer words and error pulses are gathered
  task automatic send(input oso_op_t op, input logic [15:0] arg);
    int n;
    rsp_q = {};
    err_seen = 1'b0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_arg = arg;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_op = OP_NOP;
    cmd_arg = ~arg;
    // single-cycle answers stand on the first falling edge after the take
    for (n = 0; n < 24; n++) begin
      if (err_valid === 1'b1) err_seen = 1'b1;
      if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
      if (rsp_valid === 1'b1 && rsp_last === 1'b1) break;
      @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import oso_pkg::*;
  localparam int DIV = 4;
  logic clock, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_last, err_valid;
  logic running, order_user, dir_down;
  oso_op_t cmd_op;
  logic [15:0] cmd_arg, rsp_data, err_code, setpoint, last_sp;
  logic [15:0] seen[$];
  logic [15:0] exp[$];
  int stamp[$];
  int mismatches, samples_checked, cyc;

  oso_sequencer #(.TICK_DIV(DIV)) u_dut (.CLOCK(clock), .ARST_N(arst_n), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ARG(cmd_arg), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .RSP_LAST(rsp_last), .ERR_VALID(err_valid), .ERR_CODE(err_code),
    .SETPOINT(setpoint), .RUNNING(running), .ORDER_USER(order_user), .DIR_DOWN(dir_down));
  oso_host u_host (.clk(clock), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_arg(cmd_arg), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .err_valid(err_valid));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // records every setpoint change with its cycle
  always @(negedge clock) begin
    cyc++;
    if (setpoint !== last_sp) begin
      seen.push_back(setpoint);
      stamp.push_back(cyc);
      last_sp = setpoint;
    end
  end

  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    samples_checked++;
    if (got !== e) begin
      $display("BAD %s expected %h seen %h", what, e, got);
      mismatches++;
    end
  endtask

  task automatic c(input oso_op_t op, input logic [15:0] arg);
    u_host.send(op, arg);
  endtask

  task automatic q(input oso_op_t op, input logic [15:0] e, input string what);
    u_host.send(op, 16'h0000);
    chk(what, e, (u_host.rsp_q.size() > 0) ? u_host.rsp_q[0] : 16'hXXXX);
  endtask

  task automatic err(input oso_op_t op, input logic [15:0] arg, input logic [15:0] code);
    u_host.send(op, arg);
    chk("error pulse", 16'h0001, {15'h0000, u_host.err_seen});
    chk("error code", code, err_code);
  endtask

  // runs the list from a distinct setpoint and compares the executed values
  task automatic run(input string what);
    int n;
    c(OP_SETPOINT_WR, 16'h0077);
    seen = {};
    stamp = {};
    c(OP_RUN, 16'h0000);
    n = 0;
    while (running === 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    chk(what, 16'(exp.size()), 16'(seen.size()));
    foreach (exp[i]) if (i < seen.size()) chk(what, exp[i], seen[i]);
  endtask

  initial begin
    #1000000;
    mismatches++;
    summarize();
  end

  initial begin
    arst_n = 1'b0;
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    chk("dir at reset", 16'h0000, {15'h0000, dir_down});
    q(OP_DIR_Q, TOKEN_UP, "dir query");
    q(OP_ORDER_Q, TOKEN_NATURAL, "order query");
    q(OP_COUNT_Q, COUNT_RST, "count query");
    q(OP_VALUE_PTS_Q, 16'h0000, "value points");
    c(OP_VALUE_WR, 16'h000A);
    c(OP_VALUE_WR, 16'h0014);
    c(OP_VALUE_WR, 16'h001E);
    q(OP_VALUE_PTS_Q, 16'h0003, "value points");
    c(OP_DWELL_WR, 16'h0000);
    c(OP_DWELL_WR, 16'h0001);
    err(OP_RUN, 16'h0000, ERR_CONFLICT);
    c(OP_DWELL_WR, 16'h0002);
    q(OP_DWELL_PTS_Q, 16'h0003, "dwell points");
    c(OP_QPTR_SET, 16'h0001);
    q(OP_QPTR_Q, 16'h0001, "query pointer");
    u_host.send(OP_VALUE_RD, 16'h0000);
    chk("readback words", 16'h0002, 16'(u_host.rsp_q.size()));
    chk("readback word", 16'h0014, u_host.rsp_q[0]);
    chk("readback word", 16'h001E, u_host.rsp_q[1]);
    exp = '{16'h000A, 16'h0014, 16'h001E};
    run("natural up");
    if (stamp.size() >= 3) begin
      chk("dwell step", 16'(DIV), 16'((stamp[2] - stamp[1]) - (stamp[1] - stamp[0])));
    end
    q(OP_SETPOINT_Q, 16'h001E, "setpoint after run");
    c(OP_DIR_DOWN, 16'h0000);
    chk("dir pin", 16'h0001, {15'h0000, dir_down});
    q(OP_DIR_Q, TOKEN_DOWN, "dir query");
    exp = '{16'h001E, 16'h0014, 16'h000A};
    run("natural down");
    c(OP_DIR_UP, 16'h0000);
    chk("dir pin", 16'h0000, {15'h0000, dir_down});
    c(OP_COUNT_SET, 16'h0002);
    c(OP_SKIP_SET, 16'h0001);
    q(OP_COUNT_Q, 16'h0002, "count query");
    q(OP_SKIP_Q, 16'h0001, "skip query");
    exp = '{16'h000A, 16'h0014, 16'h001E, 16'h0014, 16'h001E};
    run("repeat skip");
    c(OP_COUNT_SET, 16'h0001);
    c(OP_SKIP_SET, 16'h0000);
    c(OP_SEQ_WR, 16'h0002);
    c(OP_SEQ_WR, 16'h0000);
    c(OP_ORDER_USER, 16'h0000);
    chk("order pin", 16'h0001, {15'h0000, order_user});
    q(OP_ORDER_Q, TOKEN_USER, "order query");
    exp = '{16'h001E, 16'h000A};
    run("user up");
    c(OP_DIR_DOWN, 16'h0000);
    exp = '{16'h000A, 16'h001E};
    run("user down");
    c(OP_DIR_UP, 16'h0000);
    c(OP_ORDER_NATURAL, 16'h0000);
    chk("order pin", 16'h0000, {15'h0000, order_user});
    c(OP_COUNT_SET, 16'h0000);
    seen = {};
    c(OP_RUN, 16'h0000);
    repeat (100) @(negedge clock);
    chk("endless run", 16'h0001, {15'h0000, running});
    chk("endless steps", 16'h0001, {15'h0000, seen.size() > 6});
    err(OP_COUNT_Q, 16'h0000, ERR_CONFLICT);
    c(OP_FIX, 16'h0000);
    chk("stopped", 16'h0000, {15'h0000, running});
    c(OP_SCALE_SET, SCALE_QUARTER_CODE);
    err(OP_SETPOINT_WR, 16'h2000, ERR_RANGE);
    c(OP_SETPOINT_WR, 16'h1FFF);
    q(OP_SETPOINT_Q, 16'h1FFF, "quarter setpoint");
    c(OP_SETPOINT_WR, 16'h0005);
    c(OP_TRAN, 16'h000A);
    c(OP_SETPOINT_WR, 16'h0009);
    chk("transient value", 16'h0009, setpoint);
    repeat (30) @(negedge clock);
    chk("transient revert", 16'h0005, setpoint);
    c(OP_CLEAR, 16'h0000);
    q(OP_VALUE_PTS_Q, 16'h0000, "points after clear");
    summarize();
  end
endmodule
`default_nettype wire
